// file: hdl/acsq_top.sv
// Two-wire command sequencer and conversion control of the ADC
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ns
module acsq_top
  import acsq_pkg::*;
#(
  parameter int          CONV_CYCLES = 1000,  // Clocks per conversion
  parameter logic [2:0]  ADDR_BASE   = 3'h4   // Upper address bits
) (
  input  wire logic        clk,               // 20 MHz clock
  input  wire logic        resetn,            // Async reset, low
  input  wire logic        scl_i,             // Serial clock pin
  input  wire logic        sda_i,             // Serial data pin in
  output logic             sda_o,             // Serial data out, 0
  output logic             sda_oe_n,          // Low pulls data low
  input  wire logic [3:0]  addr_sel_i,        // Address strap pins
  input  wire logic [15:0] sample_i,          // Modulator result
  output logic             conversion_ready_pin_o,    // Ready out, 0
  output logic             conversion_ready_pin_oe_n, // Low = ready
  output logic             inputs_shorted_o,  // Inputs at mid-supply
  output logic             amp_enable_o,      // Amplifier in path
  output logic [2:0]       gain_code_o,       // Applied gain code
  output logic             conv_active_o,     // Converting
  output logic             sleep_o,           // Powered down
  output logic             irq_o,             // Level interrupt
  input  wire logic        psel,              // APB select
  input  wire logic        penable,           // APB enable
  input  wire logic        pwrite,            // APB direction
  input  wire logic [11:0] paddr,             // APB address
  input  wire logic [31:0] pwdata,            // APB write data
  output logic [31:0]      prdata,            // APB read data
  output logic             pready,            // APB ready
  output logic             pslverr            // APB error
);
  localparam int CW = $clog2(CONV_CYCLES);
  localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);

  if (CONV_CYCLES < 2) begin : g_chk
    $error("CONV_CYCLES must be at least 2");
  end

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic       scl_q1, scl_q2, scl_q3;   // Clock pin stages
  logic       sda_q1, sda_q2, sda_q3;   // Data pin stages
  logic [3:0] adr_q1, adr_q2;           // Strap stages

  // Two flops per pin; third stage is only for edge finding
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {scl_q1, scl_q2, scl_q3} <= 3'h7;
      {sda_q1, sda_q2, sda_q3} <= 3'h7;
      adr_q1 <= 4'h0;
      adr_q2 <= 4'h0;
    end else begin
      {scl_q1, scl_q2, scl_q3} <= {scl_i, scl_q1, scl_q2};
      {sda_q1, sda_q2, sda_q3} <= {sda_i, sda_q1, sda_q2};
      adr_q1 <= addr_sel_i;
      adr_q2 <= adr_q1;
    end
  end

  logic       scl_rise, scl_fall, start_c, stop_c; // Bus events
  logic [6:0] my_addr;                             // Own address
  assign scl_rise = scl_q2 & ~scl_q3;
  assign scl_fall = ~scl_q2 & scl_q3;
  assign start_c  = scl_q2 & scl_q3 & ~sda_q2 & sda_q3;
  assign stop_c   = scl_q2 & scl_q3 & sda_q2 & ~sda_q3;
  assign my_addr  = {ADDR_BASE, adr_q2};

  // ************************************************************
  // Link, command and conversion state
  // ************************************************************
  acsq_state_e     st_r, st_nxt;          // Link state
  logic [3:0]      bit_r, bit_nxt;        // Bits seen in byte
  logic [7:0]      sh_r, sh_nxt;          // Receive shifter
  logic            rw_r, rw_nxt;          // Read transfer
  logic            hold_r, hold_nxt;      // Pull data low
  logic [15:0]     tx_r, tx_nxt;          // Reply shifter
  logic            pend_r, pend_nxt;      // Write data due
  logic [1:0]      pidx_r, pidx_nxt;      // Register to write
  logic [3:0][7:0] cfg_r, cfg_nxt;        // Configuration bytes
  logic            run_r, run_nxt;        // Continuous running
  logic            one_r, one_nxt;        // Single shot pending
  logic            sleep_r, sleep_nxt;    // Power-down
  logic [15:0]     res_r, res_nxt;        // Latest result
  logic            rdy_r, rdy_nxt;        // Result waiting
  logic [CW-1:0]   cnt_r, cnt_nxt;        // Conversion timer
  acsq_evt_s       ev;                    // One-cycle events
  logic            byte_done;             // Received byte complete, command or data

  assign byte_done = scl_fall & (st_r == ACSQ_RX) & (bit_r == 4'h8);

  // Flags a skip bit set with a gain above what the analog path may use under it
  function automatic logic clash(input logic [7:0] r0);
    clash = r0[SKIP_BIT] & (r0[GAIN_MSB:GAIN_LSB] > GAIN_SKIP_MAX);
  endfunction : clash

  // Next-state logic for link, commands and converter
  always_comb begin
    st_nxt = st_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    rw_nxt = rw_r;
    hold_nxt = hold_r;
    tx_nxt = tx_r;
    pend_nxt = pend_r;
    pidx_nxt = pidx_r;
    cfg_nxt = cfg_r;
    run_nxt = run_r;
    one_nxt = one_r;
    sleep_nxt = sleep_r;
    res_nxt = res_r;
    rdy_nxt = rdy_r;
    cnt_nxt = cnt_r;
    ev = '0;
    // Converter: results only while running or one shot pending
    if (run_r | one_r) begin
      if (cnt_r == CONV_LAST) begin
        cnt_nxt = '0;
        res_nxt = sample_i;
        rdy_nxt = 1'b1;
        one_nxt = 1'b0;
        ev.data = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
    // Link: only data is ever driven, the clock never is
    if (start_c) begin
      st_nxt = ACSQ_ADDR;
      bit_nxt = 4'h0;
      hold_nxt = 1'b0;
    end else if (stop_c) begin
      st_nxt = ACSQ_IDLE;
      hold_nxt = 1'b0;
    end else if (scl_rise) begin
      case (st_r)
        ACSQ_ADDR, ACSQ_RX: begin                       // Sample data bit
          sh_nxt = {sh_r[6:0], sda_q2};
          bit_nxt = bit_r + 4'h1;
        end
        ACSQ_TX: begin
          bit_nxt = bit_r + 4'h1;
        end
        ACSQ_TACK: begin
          rw_nxt = ~sda_q2;                             // Keep going on ack
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (st_r)
        ACSQ_ADDR: begin
          if (bit_r == 4'h8) begin
            if (sh_r[7:1] == my_addr) begin
              st_nxt = ACSQ_AACK;
              rw_nxt = sh_r[0];
              hold_nxt = 1'b1;
            end else begin
              st_nxt = ACSQ_IDLE;                       // Not for us
            end
          end
        end
        ACSQ_AACK: begin
          bit_nxt = 4'h0;
          if (rw_r) begin                               // Reply phase
            st_nxt = ACSQ_TX;
            hold_nxt = ~tx_r[15];
          end else begin
            st_nxt = ACSQ_RX;
            hold_nxt = 1'b0;
          end
        end
        ACSQ_RX: begin
          if (bit_r == 4'h8) begin
            st_nxt = ACSQ_RACK;
            hold_nxt = 1'b1;
            ev.cmd = 1'b1;
            if (pend_r) begin                           // Data byte
              pend_nxt = 1'b0;
              cfg_nxt[pidx_r] = sh_r;
              ev.clash = (pidx_r == 2'h0) & clash(sh_r);
            end else if (sh_r == CMD_RESET) begin
              cfg_nxt = {4{CFG_RESET}};
              run_nxt = 1'b0;
              one_nxt = 1'b0;
              sleep_nxt = 1'b0;
              rdy_nxt = 1'b0;
              cnt_nxt = '0;
              ev.data = 1'b0;
            end else if (sh_r == CMD_START) begin
              sleep_nxt = 1'b0;
              cnt_nxt = '0;
              run_nxt = cfg_r[1][CM_BIT];
              one_nxt = ~cfg_r[1][CM_BIT];
            end else if (sh_r == CMD_SLEEP) begin
              run_nxt = 1'b0;
              one_nxt = 1'b0;
              sleep_nxt = 1'b1;
            end else if (sh_r == CMD_RDATA) begin
              tx_nxt = rdy_nxt ? res_nxt : res_r;
              rdy_nxt = 1'b0;
            end else if (sh_r[7:4] == CMD_READ_REGISTER_CMD_HI) begin
              tx_nxt = {cfg_r[sh_r[CMD_IDX_MSB:CMD_IDX_LSB]], 8'h00};
            end else if (sh_r[7:4] == CMD_WRITE_REGISTER_CMD_HI) begin
              pend_nxt = 1'b1;
              pidx_nxt = sh_r[CMD_IDX_MSB:CMD_IDX_LSB];
            end
          end
        end
        ACSQ_RACK: begin
          st_nxt = ACSQ_RX;
          bit_nxt = 4'h0;
          hold_nxt = 1'b0;
        end
        ACSQ_TX: begin
          tx_nxt = {tx_r[14:0], 1'b0};                  // Next bit
          if (bit_r == 4'h8) begin
            st_nxt = ACSQ_TACK;
            hold_nxt = 1'b0;                            // Master acks
          end else begin
            hold_nxt = ~tx_r[14];
          end
        end
        ACSQ_TACK: begin
          bit_nxt = 4'h0;
          if (rw_r) begin
            st_nxt = ACSQ_TX;
            hold_nxt = ~tx_r[15];
          end else begin
            st_nxt = ACSQ_IDLE;                         // Nack ends reply
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Registers for link, commands and converter
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= ACSQ_IDLE;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      rw_r <= 1'b0;
      hold_r <= 1'b0;
      tx_r <= 16'h0000;
      pend_r <= 1'b0;
      pidx_r <= 2'h0;
      cfg_r <= {4{CFG_RESET}};
      run_r <= 1'b0;
      one_r <= 1'b0;
      sleep_r <= 1'b0;
      res_r <= 16'h0000;
      rdy_r <= 1'b0;
      cnt_r <= '0;
    end else begin
      st_r <= st_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      rw_r <= rw_nxt;
      hold_r <= hold_nxt;
      tx_r <= tx_nxt;
      pend_r <= pend_nxt;
      pidx_r <= pidx_nxt;
      cfg_r <= cfg_nxt;
      run_r <= run_nxt;
      one_r <= one_nxt;
      sleep_r <= sleep_nxt;
      res_r <= res_nxt;
      rdy_r <= rdy_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Analog controls; skip caps the gain rather than trusting software
  assign inputs_shorted_o = (cfg_r[0][MUX_MSB:MUX_LSB] == MUX_SHORT);
  assign amp_enable_o = ~cfg_r[0][SKIP_BIT];
  assign gain_code_o = clash(cfg_r[0]) ? GAIN_SKIP_MAX
                                       : cfg_r[0][GAIN_MSB:GAIN_LSB];
  assign conv_active_o = run_r | one_r;
  assign sleep_o = sleep_r;
  assign sda_o = 1'b0;
  assign sda_oe_n = ~hold_r;
  assign conversion_ready_pin_o = 1'b0;
  assign conversion_ready_pin_oe_n = ~rdy_r;

  // ************************************************************
  // APB registers and interrupt
  // ************************************************************
  logic [EV_W-1:0] stat_r, stat_nxt;    // Sticky events
  logic [EV_W-1:0] mask_r, mask_nxt;    // Interrupt enables
  logic [31:0]     rd_r, rd_nxt;        // Read data
  logic            err_r, err_nxt;      // Unmapped access
  logic            setup, wr_acc;       // Bus phases

  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;

  // Reads latched in setup so data comes from flops in access
  always_comb begin
    rd_nxt = rd_r;
    err_nxt = err_r;
    mask_nxt = mask_r;
    stat_nxt = stat_r;
    if (wr_acc && paddr == OFS_STATUS) begin            // Write one clears
      stat_nxt = stat_r & ~pwdata[EV_W-1:0];
    end
    if (wr_acc && paddr == OFS_MASK) begin
      mask_nxt = pwdata[EV_W-1:0];
    end
    stat_nxt = stat_nxt | ev;                           // Set beats clear
    if (setup) begin
      err_nxt = 1'b0;
      case (paddr)
        OFS_STATUS: rd_nxt = {29'h0, stat_r};
        OFS_MASK:   rd_nxt = {29'h0, mask_r};
        OFS_STATE:  rd_nxt = {cfg_r[1], cfg_r[0], 12'h000, sleep_r, rdy_r, one_r, run_r};
        OFS_RESULT: rd_nxt = {16'h0000, res_r};
        default: begin
          rd_nxt = 32'h0;
          err_nxt = 1'b1;
        end
      endcase
    end
  end

  // Bus register stage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stat_r <= '0;
      mask_r <= '0;
      rd_r <= 32'h0;
      err_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      rd_r <= rd_nxt;
      err_r <= err_nxt;
    end
  end

  assign prdata = rd_r;
  assign pready = psel & penable;
  assign pslverr = psel & penable & err_r;
  assign irq_o = |(stat_r & mask_r);

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_cmd(logic [7:0] c);
    byte_done && !pend_r && sh_r == c;
  endsequence
  sequence s_nib(logic [3:0] n);
    byte_done && !pend_r && sh_r[7:4] == n;
  endsequence

  reset_cmd_a: assert property (s_cmd(CMD_RESET) |=> cfg_r == {4{CFG_RESET}} && !run_r
    && conversion_ready_pin_oe_n) else $error("reset command left state");
  write_register_cmd_store_a: assert property (byte_done && pend_r |=> cfg_r[$past(pidx_r)] == $past(sh_r))
    else $error("write data not stored");
  read_register_cmd_load_a: assert property (s_nib(CMD_READ_REGISTER_CMD_HI) |=> tx_r[15:8]
    == cfg_r[$past(sh_r[CMD_IDX_MSB:CMD_IDX_LSB])]) else $error("read reg wrong");
  // Result spacing is left to ready_low_a; a long plain delay would choke the tools
  start_run_a: assert property (s_cmd(CMD_START) && cfg_r[1][CM_BIT] |=> run_r
    && cnt_r == '0) else $error("start did not run");
  ready_low_a: assert property ($rose(rdy_r) |-> $past(cnt_r) == CONV_LAST
    && res_r == $past(sample_i)) else $error("ready without result");
  rdata_load_a: assert property (s_cmd(CMD_RDATA) && !rdy_nxt |=> tx_r == res_r
    && conversion_ready_pin_oe_n) else $error("result not loaded");
  sleep_stop_a: assert property (s_cmd(CMD_SLEEP) |=> sleep_o && !conv_active_o
    ##1 !$rose(rdy_r)) else $error("sleep did not stop");
  mux_short_a: assert property (byte_done && pend_r && pidx_r == 2'h0
    |=> inputs_shorted_o == ($past(sh_r[MUX_MSB:MUX_LSB]) == MUX_SHORT))
    else $error("short switch wrong");
  gain_cap_a: assert property (!amp_enable_o |-> gain_code_o <= GAIN_SKIP_MAX)
    else $error("gain above four without amplifier");
  addr_ack_a: assert property (st_r == ACSQ_ADDR && st_nxt == ACSQ_AACK
    |-> sh_r[7:1] == my_addr ##1 !sda_oe_n) else $error("ack on foreign address");
endmodule : acsq_top

// file: hdl/acsq_pkg.sv
// Constants, codes and carriers for the ADC two-wire command sequencer
// Function
// - Reset command restores power-on configuration
// - Write command stores following byte into register
// - Read command returns addressed register contents
// - Start command begins conversions, continuous or single shot per register 1
// - Ready pin falls when new result waits
// - Read-result command returns two result bytes
// - Sleep command stops conversions, powers down
// - Shorted-input code ties inputs to mid-supply
// - Amplifier skip limits gain to four
// - Device never holds the clock line low
package acsq_pkg;
  // ************************************************************
  // Command codes
  // ************************************************************
  localparam logic [7:0] CMD_RESET = 8'h06;    // Back to defaults
  localparam logic [7:0] CMD_START = 8'h08;    // Begin converting
  localparam logic [7:0] CMD_SLEEP = 8'h02;    // Power down
  localparam logic [7:0] CMD_RDATA = 8'h10;    // Fetch result
  localparam logic [3:0] CMD_READ_REGISTER_CMD_HI = 4'h2;   // Read-register nibble
  localparam logic [3:0] CMD_WRITE_REGISTER_CMD_HI = 4'h4;   // Write-register nibble
  localparam int CMD_IDX_MSB = 3;              // Register select bits
  localparam int CMD_IDX_LSB = 2;
  // ************************************************************
  // Configuration field layout
  // ************************************************************
  localparam int MUX_MSB = 7;                  // Input select field
  localparam int MUX_LSB = 4;
  localparam int GAIN_MSB = 3;                 // Gain code, 2**code
  localparam int GAIN_LSB = 1;
  localparam int SKIP_BIT = 0;                 // Amplifier skip bit
  localparam int CM_BIT = 3;                   // Continuous mode, reg 1
  localparam logic [3:0] MUX_SHORT = 4'he;     // Inputs to mid-supply
  localparam logic [2:0] GAIN_SKIP_MAX = 3'h2; // Gain 4 with skip
  localparam logic [7:0] CFG_RESET = 8'h00;    // Power-on value
  // ************************************************************
  // Register bus map and status bits
  // ************************************************************
  localparam logic [11:0] OFS_STATUS = 12'h000; // Sticky events, W1C
  localparam logic [11:0] OFS_MASK = 12'h004;   // Interrupt mask
  localparam logic [11:0] OFS_STATE = 12'h008;  // Live state
  localparam logic [11:0] OFS_RESULT = 12'h00c; // Latest result
  localparam int EV_DATA = 0;                   // New result
  localparam int EV_CMD = 1;                    // Command taken
  localparam int EV_CLASH = 2;                  // Gain needs amplifier
  localparam int EV_W = 3;
  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    ACSQ_IDLE = 3'h0, ACSQ_ADDR = 3'h1, ACSQ_AACK = 3'h3, ACSQ_RX = 3'h2,
    ACSQ_RACK = 3'h6, ACSQ_TX = 3'h7, ACSQ_TACK = 3'h5
  } acsq_state_e;
  typedef struct packed {
    logic clash;  // Gain clash
    logic cmd;    // Command
    logic data;   // New data
  } acsq_evt_s;
endpackage : acsq_pkg

// file: verification/acsq_host.sv
// Host controller model for the two-wire link
`timescale 1ns/1ns
module acsq_host
  import acsq_pkg::*;
#(
  parameter int POR_CLKS = 10000 // 500 us of clocks
) (
  input  wire logic       clk,       // Bench clock
  input  wire logic       sda_bus,   // Data line
  input  wire logic       ready_bus, // Ready line
  input  wire logic [6:0] dev_addr,  // Target
  output logic            scl,       // Clock, host only
  output logic            sda_oe_n   // Low pulls data
);
  logic por_done; // Settled
  // ********************
  // Settling wait, lines idle high
  // ********************
  initial begin
    scl = 1'b1;
    sda_oe_n = 1'b1;
    por_done = 1'b0;
    repeat (POR_CLKS) @(posedge clk);
    por_done = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // One step of two clocks; clock stands still between frames
  task automatic step(input logic c, input logic d);
    tick(2);
    scl <= c;
    sda_oe_n <= d;
  endtask : step
  // Read mid-way through the high phase, past the device sync delay
  task automatic bit_io(input logic o, output logic i);
    step(1'b0, o);
    step(1'b1, o);
    step(1'b1, o);
    i = sda_bus;
    step(1'b0, o);
  endtask : bit_io
  task automatic byte_io(input logic [7:0] o, input logic ao,
                         output logic [7:0] i, output logic ai);
    for (int k = 7; k >= 0; k--) bit_io(o[k], i[k]);
    bit_io(ao, ai);
  endtask : byte_io
  // Command write, then reply read after a repeated start
  task automatic txn(input logic [7:0] c, input logic wd, input logic [7:0] d,
                     input int nr, output logic [15:0] q, output logic ok);
    logic [7:0] b;
    logic       a;
    ok = 1'b1;
    q = 16'h0;
    while (!por_done) tick(1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    byte_io({dev_addr, 1'b0}, 1'b1, b, a);
    ok &= ~a;
    byte_io(c, 1'b1, b, a);
    ok &= ~a;
    if (wd) begin // Data byte of a register write
      byte_io(d, 1'b1, b, a);
      ok &= ~a;
    end
    if (nr > 0) begin
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
      byte_io({dev_addr, 1'b1}, 1'b1, b, a);
      ok &= ~a;
      for (int k = 0; k < nr; k++) begin // Nack ends reply
        byte_io(8'hff, k == nr - 1, b, a);
        q = {q[7:0], b};
      end
    end
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask : txn
  // Bounded wait for the ready line to go low
  task automatic wait_ready(output logic ok);
    ok = 1'b0;
    for (int n = 0; n < 4000 && !ok; n++) begin
      tick(1);
      ok = ~ready_bus;
    end
  endtask : wait_ready
endmodule : acsq_host

// file: verification/acsq_top_tb_top.sv
// Self-checking bench of the ADC command sequencer
`timescale 1ns/1ns
module acsq_top_tb_top
  import acsq_pkg::*;
;
  localparam int CONV = 600; // Longer than one result read
  logic        clk, resetn, scl, h_oe_n, sda_oe_n, rdy_oe_n; // Clock and lines
  logic        shorted, amp_en, conv, slp, irq, last_err;    // Design levels
  logic        psel, penable, pwrite, pready, pslverr;       // APB control
  logic [2:0]  gain;          // Applied gain code
  logic [3:0]  addr_sel;      // Straps
  logic [6:0]  host_addr;     // Host target
  logic [11:0] paddr;         // APB address
  logic [15:0] sample;        // Modulator word
  logic [31:0] pwdata, prdata; // APB data
  logic [9:0]  pins;          // Level outputs
  int          n_mismatch, check_count;
  wire         sda_bus = h_oe_n & sda_oe_n; // Pull-up when both release
  assign pins = {conv, slp, shorted, amp_en, gain, rdy_oe_n, sda_oe_n, irq};
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  acsq_top #(.CONV_CYCLES(CONV), .ADDR_BASE(3'h4)) i_acsq_top (
    .clk(clk), .resetn(resetn), .scl_i(scl), .sda_i(sda_bus), .sda_o(),
    .sda_oe_n(sda_oe_n), .addr_sel_i(addr_sel), .sample_i(sample),
    .conversion_ready_pin_o(), .conversion_ready_pin_oe_n(rdy_oe_n),
    .inputs_shorted_o(shorted), .amp_enable_o(amp_en), .gain_code_o(gain),
    .conv_active_o(conv), .sleep_o(slp), .irq_o(irq), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  acsq_host i_acsq_host (.clk(clk), .sda_bus(sda_bus), .ready_bus(rdy_oe_n),
    .dev_addr(host_addr), .scl(scl), .sda_oe_n(h_oe_n));
  // ********************
  // Checks and verdict
  // ********************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask : chk
  task automatic finish_test();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test
  // Level outputs expected from a register 0 value; ready and data idle high
  task automatic pchk(input logic cv, input logic sl, input logic [7:0] r);
    logic [2:0] g;
    g = r[GAIN_MSB:GAIN_LSB];
    if (r[SKIP_BIT] && g > GAIN_SKIP_MAX) g = GAIN_SKIP_MAX; // Skip caps gain
    chk("pins", {22'h0, cv, sl, r[MUX_MSB:MUX_LSB] == MUX_SHORT, ~r[SKIP_BIT], g,
        3'b110}, {22'h0, pins});
  endtask : pchk
  // One APB transfer; waits for pready within a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin // Hung bus
      n_mismatch++;
      finish_test();
    end
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic link(input logic [7:0] c, input logic wd, input logic [7:0] d,
                      input int nr, output logic [15:0] q);
    logic ok;
    i_acsq_host.txn(c, wd, d, nr, q, ok);
    chk("ack", 32'h1, {31'h0, ok});
  endtask : link
  // ********************
  // Main sequence
  // ********************
  initial begin : main
    logic [31:0] q;
    logic [15:0] r, e;
    logic [7:0]  r0;
    logic        ok;
    logic [7:0]  corner [4];
    int          acc_e, acc_r; // Offset sums, expected and seen
    corner = '{8'he0, 8'h09, 8'h05, 8'h0f}; // Short, clash, boundary, top
    void'($urandom(88040));
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    addr_sel = 4'($urandom());
    host_addr = {3'h4, addr_sel};
    sample = 16'($urandom());
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    pchk(1'b0, 1'b0, CFG_RESET);
    apb(1'b0, 12'h010, 32'h0, q);
    chk("slverr", 32'h1, {31'h0, last_err});
    chk("unmapped", 32'h0, q);
    link(CMD_RESET, 1'b0, 8'h00, 0, r);
    host_addr <= {3'h4, ~addr_sel}; // Foreign address is ignored
    i_acsq_host.txn(CMD_START, 1'b0, 8'h00, 0, r, ok);
    chk("nack", 32'h0, {31'h0, ok});
    host_addr <= {3'h4, addr_sel};
    pchk(1'b0, 1'b0, CFG_RESET);
    for (int i = 0; i < 8; i++) begin
      r0 = (i < 4) ? corner[i] : 8'($urandom());
      link({CMD_WRITE_REGISTER_CMD_HI, 4'h0}, 1'b1, r0, 0, r);
      pchk(1'b0, 1'b0, r0);
      apb(1'b0, OFS_STATUS, 32'h0, q);
      ok = r0[SKIP_BIT] && (r0[GAIN_MSB:GAIN_LSB] > GAIN_SKIP_MAX);
      chk("status", {29'h0, ok, 2'b10}, q);
      apb(1'b1, OFS_STATUS, 32'h7, q);
      link({CMD_READ_REGISTER_CMD_HI, 4'h0}, 1'b0, 8'h00, 1, r);
      chk("reg0", {24'h0, r0}, {16'h0, r});
    end
    // Offset calibration: single shots with shorted inputs, averaged
    link({CMD_WRITE_REGISTER_CMD_HI, 4'h0}, 1'b1, 8'he0, 0, r);
    acc_e = 0;
    acc_r = 0;
    for (int i = 0; i < 2; i++) begin // Register 1 still clear: single shot
      link(CMD_START, 1'b0, 8'h00, 0, r);
      i_acsq_host.wait_ready(ok);
      chk("shot_ready", 32'h1, {31'h0, ok});
      acc_e += int'($signed(sample));
      link(CMD_RDATA, 1'b0, 8'h00, 2, r);
      acc_r += int'($signed(r));
      sample <= 16'($urandom());
      chk("shot_done", 32'h0, {31'h0, conv});
    end
    chk("offset", 32'(acc_e / 2), 32'(acc_r / 2));
    link({CMD_WRITE_REGISTER_CMD_HI, 4'h0}, 1'b1, 8'h08, 0, r);
    link({CMD_WRITE_REGISTER_CMD_HI, 4'h4}, 1'b1, 8'h08, 0, r);
    link({CMD_READ_REGISTER_CMD_HI, 4'h4}, 1'b0, 8'h00, 1, r);
    chk("reg1", 32'h8, {16'h0, r});
    link(CMD_START, 1'b0, 8'h00, 0, r);
    pchk(1'b1, 1'b0, 8'h08);
    for (int i = 0; i < 3; i++) begin
      i_acsq_host.wait_ready(ok);
      chk("ready", 32'h1, {31'h0, ok});
      e = sample;
      sample <= 16'($urandom()); // Next conversion sees a new word
      link(CMD_RDATA, 1'b0, 8'h00, 2, r);
      chk("result", {16'h0, e}, {16'h0, r});
      chk("ready_hi", 32'h1, {31'h0, rdy_oe_n});
    end
    chk("running", 32'h1, {31'h0, conv});
    link(CMD_SLEEP, 1'b0, 8'h00, 0, r);
    chk("sleep", 32'h1, {30'h0, conv, slp});
    apb(1'b1, OFS_MASK, 32'h1, q);
    chk("irq_on", 32'h1, {31'h0, irq});
    apb(1'b1, OFS_MASK, 32'h0, q);
    chk("irq_masked", 32'h0, {31'h0, irq});
    apb(1'b1, OFS_MASK, 32'h1, q);
    apb(1'b1, OFS_STATUS, 32'h1, q);
    chk("irq_clear", 32'h0, {31'h0, irq});
    link(CMD_RESET, 1'b0, 8'h00, 0, r);
    pchk(1'b0, 1'b0, CFG_RESET);
    apb(1'b0, OFS_STATE, 32'h0, q);
    chk("state", 32'h0, q);
    finish_test();
  end
  // Watchdog for a hang anywhere
  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end
endmodule : acsq_top_tb_top
